// file: bench/ssps_core_bench.sv
`timescale 1ns/1ns
module ssps_core_bench;
   typedef struct {logic pol; logic phase; logic [7:0] dev; logic [7:0] mst;} ssps_row_t;
   logic clk_sys, resetn, bus_wr, pol, phase, sk, si, sk_q, shift_done_irq, exp_so;
   logic tgl = 1'h0;
   logic [7:0] bus_addr, bus_wdata, bus_rdata, port_in, port_out, port_oe, v, rx;
   int num_errors = 0;
   int tests_run = 0;
   int pulses = 0;
   int edges = 0;
   ssps_row_t rows [4] = '{'{1'h0, 1'h0, 8'ha5, 8'h3c}, '{1'h0, 1'h1, 8'h81, 8'h7e},
      '{1'h1, 1'h0, 8'h5a, 8'hc3}, '{1'h1, 1'h1, 8'h1f, 8'he0}};
   logic [7:0] regs [6] = '{ssps_pkg::ADDR_PORT_DATA, ssps_pkg::ADDR_PORT_CFG,
      ssps_pkg::ADDR_SHIFT, ssps_pkg::ADDR_CTRL, ssps_pkg::ADDR_PSW, 8'h80};
   // undriven serial-out toggles so a floating pin never reads as data
   assign port_in = {1'h0, si, port_oe[5] ? port_out[5] : sk, port_oe[4] ? port_out[4] : tgl,
      4'h0};
   ssps_core #(.TC_DIV(2)) uut (.clk_sys(clk_sys), .resetn(resetn), .bus_addr(bus_addr),
      .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rdata(bus_rdata), .port_in(port_in),
      .port_out(port_out), .port_oe(port_oe), .shift_done_irq(shift_done_irq));
   ssps_spi_master m (.clk_sys(clk_sys), .pol(pol), .phase(phase), .so_pin(port_in[4]),
      .sk(sk), .si(si));
   initial
   begin
      clk_sys = 1'h0;
      forever #5 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys)
   begin
      tgl <= ~tgl;
      sk_q <= port_out[5];
      if (shift_done_irq === 1'h1) pulses++;
      if (port_out[5] === 1'h1 && sk_q === 1'h0 && port_oe[5] === 1'h1) edges++;
   end
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      bus_addr <= a;
      bus_wdata <= d;
      bus_wr <= 1'h1;
      @(posedge clk_sys);
      bus_wr <= 1'h0;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk_sys);
      bus_addr <= a;
      repeat (2) @(posedge clk_sys);
      #1 d = bus_rdata;
   endtask : rd
   task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
      tests_run++;
      if (got !== exp)
      begin
         num_errors++;
         $display("BAD %s expected %h seen %h", name, exp, got);
      end
   endtask : chk
   task automatic results;
      $display("compares %0d mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : results
   initial
   begin
      #300000;
      num_errors++;
      results();
   end
   initial
   begin
      resetn = 1'h0;
      bus_wr = 1'h0;
      bus_addr = 8'h00;
      bus_wdata = 8'h00;
      pol = 1'h0;
      phase = 1'h0;
      repeat (12) @(posedge clk_sys);
      resetn <= 1'h1;
      chk("oe_reset", 8'h00, port_oe);
      foreach (regs[i])
      begin
         rd(regs[i], v);
         chk("reset_value", 8'h00, v);
      end
      $display("reset test done");
      foreach (rows[i])
      begin
         pol <= rows[i].pol;
         phase <= rows[i].phase;
         wr(ssps_pkg::ADDR_PORT_DATA, {2'h0, rows[i].pol, 5'h00});
         wr(ssps_pkg::ADDR_PORT_CFG, {1'h0, rows[i].phase, 6'h10});
         wr(ssps_pkg::ADDR_CTRL, 8'h88);
         wr(ssps_pkg::ADDR_SHIFT, rows[i].dev);
         wr(ssps_pkg::ADDR_PSW, 8'h04);
         pulses = 0;
         m.frame(rows[i].mst, rx);
         repeat (10) @(posedge clk_sys);
         v = port_out;
         exp_so = rows[i].phase ? rows[i].dev[0] : rows[i].mst[7];
         chk("so_last", {7'h00, exp_so}, {7'h00, v[4]});
         chk("pin_roles", 8'h10, port_oe & 8'h30);
         chk("master_rx", rows[i].dev, rx);
         rd(ssps_pkg::ADDR_SHIFT, rx);
         chk("shift_reg", rows[i].mst, rx);
         rd(ssps_pkg::ADDR_PSW, rx);
         chk("busy_clear", 8'h00, rx);
         chk("done_pulses", 8'h01, 8'(pulses));
         chk("so_hold", {7'h00, exp_so}, {7'h00, port_out[4]});
         $display("row %0d test done", i);
      end
      // shifting refused while busy is clear
      wr(ssps_pkg::ADDR_SHIFT, 8'h96);
      wr(ssps_pkg::ADDR_PSW, 8'h00);
      m.frame(8'h0f, rx);
      rd(ssps_pkg::ADDR_SHIFT, v);
      chk("idle_shift", 8'h96, v);
      wr(ssps_pkg::ADDR_CTRL, 8'h08);
      wr(ssps_pkg::ADDR_PSW, 8'h04);
      pulses = 0;
      m.frame(8'h2d, rx);
      repeat (10) @(posedge clk_sys);
      chk("no_pulse", 8'h00, 8'(pulses));
      rd(ssps_pkg::ADDR_SHIFT, v);
      chk("masked_shift", 8'h2d, v);
      $display("refusal test done");
      wr(ssps_pkg::ADDR_PORT_PINS, 8'hff);
      rd(ssps_pkg::ADDR_PORT_PINS, v);
      chk("pins_ro", port_in & 8'he0, v & 8'he0);
      wr(ssps_pkg::ADDR_PORT_CFG, 8'h30);
      wr(ssps_pkg::ADDR_CTRL, 8'h08);
      wr(ssps_pkg::ADDR_SHIFT, 8'h55);
      edges = 0;
      wr(ssps_pkg::ADDR_PSW, 8'h04);
      repeat (200) @(posedge clk_sys);
      chk("master_oe", 8'h30, port_oe & 8'h30);
      chk("master_edges", 8'h08, 8'(edges));
      rd(ssps_pkg::ADDR_PSW, v);
      chk("master_busy", 8'h00, v);
      // slowest rate: a fast clock would have finished long before the busy read
      wr(ssps_pkg::ADDR_CTRL, 8'h0a);
      edges = 0;
      wr(ssps_pkg::ADDR_PSW, 8'h04);
      repeat (60) @(posedge clk_sys);
      rd(ssps_pkg::ADDR_PSW, v);
      chk("slow_busy", 8'h04, v);
      repeat (150) @(posedge clk_sys);
      chk("slow_edges", 8'h08, 8'(edges));
      wr(ssps_pkg::ADDR_PORT_CFG, 8'h20);
      repeat (2) @(posedge clk_sys);
      chk("so_tristate", 8'h20, port_oe & 8'h30);
      $display("master test done");
      results();
   end
endmodule : ssps_core_bench

// file: bench/ssps_spi_master.sv
`timescale 1ns/1ns
module ssps_spi_master (
   input wire logic clk_sys, // system clock
   input wire logic pol,     // idle level of the shift clock
   input wire logic phase,   // phase select, mirrors the device setting
   input wire logic so_pin,  // serial-out wire from the device
   output logic sk,          // shift clock to the device
   output logic si           // serial data to the device
);
   logic act = 1'h0;
   logic lead = 1'h0;
   // clock stands at its idle level outside frames
   assign sk = act ? (pol ^ lead) : pol;
   initial si = 1'h0;
   // half period of 8 clk_sys gives the 160 ns link clock
   task automatic frame(input logic [7:0] tx, output logic [7:0] rx);
      act = 1'h1;
      for (int i = 7; i >= 0; i--)
      begin
         repeat (6) @(posedge clk_sys);
         si <= tx[i];
         repeat (2) @(posedge clk_sys);
         lead <= 1'h1;
         if (!phase) rx[i] = so_pin;
         repeat (8) @(posedge clk_sys);
         lead <= 1'h0;
         if (phase) rx[i] = so_pin;
      end
      repeat (6) @(posedge clk_sys);
      // released data line must not keep a valid-looking bit
      si <= ~si;
      act = 1'h0;
   endtask : frame
endmodule : ssps_spi_master

// file: verilog/ssps_core.sv
// Functional notes
// - Port enable routes serial-out and shift-clock onto port pins.
// - Serial-out pin driven when its config bit is 1, else high impedance.
// - Shift-clock config bit 1 drives internal clock, 0 accepts external.
// - After eight pulses busy clears and shifting stops.
// - Port data bit 5 selects shift-clock idle level, 0 low, 1 high.
// - Normal phase samples on rising edge, drives on falling edge.
// - Alternate phase samples on falling edge, drives on rising edge.
// - Shift register advances on falling edge in normal phase.
// - Config bit 6 selects clock phase, 0 normal, 1 alternate.
// - Phase select is cleared at power-up.
// - Idle-high polarity swaps the sampling and driving edges.
// - Setting busy starts shifting; clearing it early stops it.
// - When enabled an interrupt is raised after eight bits.
// - Master rate bits give periods of two, four or eight ticks of the TC_DIV prescaler.
`timescale 1ns/1ns
module ssps_core #(
   parameter int TC_DIV = ssps_pkg::TC_DIV_DEFAULT
) (
   input wire logic clk_sys,          // system clock
   input wire logic resetn,           // async reset, active low
   input wire logic [7:0] bus_addr,   // data address
   input wire logic [7:0] bus_wdata,  // write data
   input wire logic bus_wr,           // write strobe
   output logic [7:0] bus_rdata,      // read data, one cycle after address
   input wire logic [7:0] port_in,    // pin levels
   output logic [7:0] port_out,       // pin drive values
   output logic [7:0] port_oe,        // pin drive enables
   output logic shift_done_irq        // one-cycle pulse, eight bits shifted
);
   logic [7:0] pdata, pcfg, serial_shift_register, ctrl, processor_status_word;
   logic [7:0] next_pdata, next_pcfg, next_sio, next_ctrl, next_psw;
   logic [7:0] pin_s1, pin_s2;
   logic sk_prev, next_sk_prev;
   logic sk_int, next_sk_int;
   logic so_q, next_so_q;
   logic hold, next_hold;
   logic [3:0] bit_cnt, next_bit_cnt;
   logic [2:0] half_cnt, next_half_cnt;
   logic [15:0] tc_cnt, next_tc_cnt;
   logic [7:0] next_rdata, next_port_out, next_port_oe;
   logic next_irq;
   logic serial_port_enable, master, pol, phase, alt, busy, active, tc_tick;
   logic sk_level, rise, fall, sample_now, drive_now, shift_now, shift_in;
   logic sio_wr, psw_wr, done;
   logic [2:0] half_ticks;

   assign serial_port_enable = ctrl[ssps_pkg::CTRL_ENABLE];
   assign master = pcfg[ssps_pkg::PIN_SK];
   assign pol = pdata[ssps_pkg::POL_BIT];
   assign phase = pcfg[ssps_pkg::PHASE_BIT];
   assign alt = phase ^ pol;
   assign busy = processor_status_word[ssps_pkg::PSW_BUSY];
   assign active = busy && serial_port_enable;
   assign sio_wr = bus_wr && (bus_addr == ssps_pkg::ADDR_SHIFT);
   assign psw_wr = bus_wr && (bus_addr == ssps_pkg::ADDR_PSW);
   assign tc_tick = (tc_cnt == 16'(TC_DIV - 1));

   // slave clock comes from the pin through the synchroniser; the far end owns it
   assign sk_level = master ? sk_int : pin_s2[ssps_pkg::PIN_SK];
   assign rise = sk_level && !sk_prev;
   assign fall = !sk_level && sk_prev;
   assign sample_now = active && (alt ? fall : rise);
   assign drive_now = active && (alt ? rise : fall);
   // phase 0: drive edge returns the clock to idle, so shift there with the held
   // sample; phase 1: the last edge is a sample edge, so shift right on it
   assign shift_now = phase ? sample_now : (drive_now && bit_cnt != 4'h0 ? 1'b1 : 1'b0);
   assign shift_in = phase ? pin_s2[ssps_pkg::PIN_SI] : hold;
   // phase 0 counter runs one ahead of the shifts, so its eighth shift sees eight
   assign done = shift_now && (bit_cnt == (phase ? 4'(ssps_pkg::XFER_BITS - 1) :
      4'(ssps_pkg::XFER_BITS)));

   always_comb
   begin
      case ({ctrl[ssps_pkg::CTRL_RATE_HI], ctrl[ssps_pkg::CTRL_RATE_LO]})
         2'b00: half_ticks = 3'h1;
         2'b01: half_ticks = 3'h2;
         default: half_ticks = 3'h4;
      endcase
   end

   always_comb
   begin
      next_pdata = pdata;
      next_pcfg = pcfg;
      next_ctrl = ctrl;
      next_psw = processor_status_word;
      next_sio = serial_shift_register;
      next_so_q = so_q;
      next_hold = hold;
      next_bit_cnt = bit_cnt;
      next_half_cnt = half_cnt;
      next_sk_int = sk_int;
      next_sk_prev = sk_level;
      next_tc_cnt = tc_tick ? 16'h0000 : tc_cnt + 16'h0001;
      next_irq = 1'b0;
      // internal clock only toggles while a master transfer is live
      if (active && master)
      begin
         if (tc_tick)
         begin
            if (half_cnt == half_ticks - 3'h1)
            begin
               next_half_cnt = 3'h0;
               next_sk_int = !sk_int;
            end
            else
               next_half_cnt = half_cnt + 3'h1;
         end
      end
      else
      begin
         next_half_cnt = 3'h0;
         next_sk_int = pol;
      end
      if (!active)
      begin
         next_bit_cnt = 4'h0;
      end
      else
      begin
         if (sample_now)
            next_hold = pin_s2[ssps_pkg::PIN_SI];
         if (phase && sample_now)
            next_bit_cnt = bit_cnt + 4'h1;
         // phase 0 counts pending samples; a shift needs one taken before it
         if (!phase && sample_now && bit_cnt == 4'h0)
            next_bit_cnt = 4'h1;
         if (shift_now)
         begin
            next_sio = {serial_shift_register[6:0], shift_in};
            if (!phase)
               next_bit_cnt = bit_cnt + 4'h1;
         end
         if (drive_now)
            next_so_q = next_sio[7];
         if (done)
         begin
            next_psw[ssps_pkg::PSW_BUSY] = 1'b0;
            next_irq = ctrl[ssps_pkg::CTRL_IRQ_EN];
         end
      end
      // software access wins; a busy write in the done cycle is kept
      if (bus_wr)
      begin
         case (bus_addr)
            ssps_pkg::ADDR_PORT_DATA: next_pdata = bus_wdata;
            ssps_pkg::ADDR_PORT_CFG: next_pcfg = bus_wdata;
            ssps_pkg::ADDR_CTRL: next_ctrl = bus_wdata;
            ssps_pkg::ADDR_PSW: next_psw = bus_wdata;
            ssps_pkg::ADDR_SHIFT:
            begin
               next_sio = bus_wdata;
               next_so_q = bus_wdata[7];
            end
            default: next_pdata = pdata;
         endcase
      end
      // read data follows the address one cycle later
      case (bus_addr)
         ssps_pkg::ADDR_PORT_DATA: next_rdata = pdata;
         ssps_pkg::ADDR_PORT_CFG: next_rdata = pcfg;
         ssps_pkg::ADDR_PORT_PINS: next_rdata = pin_s2;
         ssps_pkg::ADDR_SHIFT: next_rdata = serial_shift_register;
         ssps_pkg::ADDR_CTRL: next_rdata = ctrl;
         ssps_pkg::ADDR_PSW: next_rdata = processor_status_word;
         default: next_rdata = 8'h00;
      endcase
      next_port_out = pdata;
      next_port_oe = pcfg;
      if (serial_port_enable)
      begin
         next_port_out[ssps_pkg::PIN_SO] = so_q;
         next_port_oe[ssps_pkg::PIN_SO] = pcfg[ssps_pkg::PIN_SO];
         next_port_out[ssps_pkg::PIN_SK] = sk_int;
         next_port_oe[ssps_pkg::PIN_SK] = master;
      end
   end

   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         pdata <= ssps_pkg::RST_PORT_DATA;
         pcfg <= ssps_pkg::RST_PORT_CFG;
         ctrl <= ssps_pkg::RST_CTRL;
         processor_status_word <= ssps_pkg::RST_PSW;
         serial_shift_register <= ssps_pkg::RST_SHIFT;
         so_q <= 1'b0;
         hold <= 1'b0;
         bit_cnt <= 4'h0;
         half_cnt <= 3'h0;
         sk_int <= 1'b0;
         sk_prev <= 1'b0;
         tc_cnt <= 16'h0000;
         pin_s1 <= 8'h00;
         pin_s2 <= 8'h00;
         bus_rdata <= 8'h00;
         port_out <= 8'h00;
         port_oe <= 8'h00;
         shift_done_irq <= 1'b0;
      end
      else
      begin
         pdata <= next_pdata;
         pcfg <= next_pcfg;
         ctrl <= next_ctrl;
         processor_status_word <= next_psw;
         serial_shift_register <= next_sio;
         so_q <= next_so_q;
         hold <= next_hold;
         bit_cnt <= next_bit_cnt;
         half_cnt <= next_half_cnt;
         sk_int <= next_sk_int;
         sk_prev <= next_sk_prev;
         tc_cnt <= next_tc_cnt;
         pin_s1 <= port_in;
         pin_s2 <= pin_s1;
         bus_rdata <= next_rdata;
         port_out <= next_port_out;
         port_oe <= next_port_oe;
         shift_done_irq <= next_irq;
      end
   end

   a_phase_reset: assert property (@(posedge clk_sys) $rose(resetn) |-> !pcfg[6])
      else $error("phase select not cleared by reset");
   a_so_tristate: assert property (@(posedge clk_sys) disable iff (!resetn)
      (serial_port_enable && !pcfg[4]) |=> !port_oe[4])
      else $error("serial-out driven while its config bit is 0");
   a_sk_slave_in: assert property (@(posedge clk_sys) disable iff (!resetn)
      (serial_port_enable && !pcfg[5]) |=> !port_oe[5])
      else $error("shift-clock pin driven in slave operation");
   a_sk_master_out: assert property (@(posedge clk_sys) disable iff (!resetn)
      (serial_port_enable && pcfg[5]) |=> (port_oe[5] && port_out[5] == $past(sk_int)))
      else $error("internal shift clock not routed to pin");
   a_busy_done: assert property (@(posedge clk_sys) disable iff (!resetn)
      (done && !psw_wr) |=> (!busy && shift_done_irq == $past(ctrl[7])))
      else $error("busy not cleared after eighth shift");
   a_idle_frozen: assert property (@(posedge clk_sys) disable iff (!resetn)
      (!busy && !sio_wr) |=> ($stable(serial_shift_register) && $stable(so_q)))
      else $error("shift register moved while idle");
   a_msb_first: assert property (@(posedge clk_sys) disable iff (!resetn)
      (shift_now && !sio_wr) |=> serial_shift_register == {$past(serial_shift_register[6:0]), $past(shift_in)})
      else $error("shift direction wrong");
   a_drive_edge: assert property (@(posedge clk_sys) disable iff (!resetn)
      (drive_now && !sio_wr) |=> so_q == serial_shift_register[7])
      else $error("serial-out not updated on drive edge");
   a_normal_fall: assert property (@(posedge clk_sys) disable iff (!resetn)
      (shift_now && !phase && !pol) |-> fall)
      else $error("normal phase shift off the falling edge");
endmodule : ssps_core

// file: verilog/ssps_pkg.sv
package ssps_pkg;
   // data address space offsets
   localparam logic [7:0] ADDR_PORT_DATA = 8'hd4;
   localparam logic [7:0] ADDR_PORT_CFG = 8'hd5;
   localparam logic [7:0] ADDR_PORT_PINS = 8'hd6;
   localparam logic [7:0] ADDR_SHIFT = 8'he9;
   localparam logic [7:0] ADDR_CTRL = 8'hee;
   localparam logic [7:0] ADDR_PSW = 8'hef;
   // reset values
   localparam logic [7:0] RST_PORT_DATA = 8'h00;
   localparam logic [7:0] RST_PORT_CFG = 8'h00;
   localparam logic [7:0] RST_SHIFT = 8'h00;
   localparam logic [7:0] RST_CTRL = 8'h00;
   localparam logic [7:0] RST_PSW = 8'h00;
   // field positions
   localparam int PIN_SO = 4;
   localparam int PIN_SK = 5;
   localparam int PIN_SI = 6;
   localparam int POL_BIT = 5;
   localparam int PHASE_BIT = 6;
   localparam int CTRL_RATE_LO = 0;
   localparam int CTRL_RATE_HI = 1;
   localparam int CTRL_ENABLE = 3;
   localparam int CTRL_IRQ_EN = 7;
   localparam int PSW_BUSY = 2;
   // timing
   localparam int XFER_BITS = 8;
   localparam int TC_DIV_DEFAULT = 10;
endpackage : ssps_pkg
